// ===== include/wake_standby_pkg.sv
/*
 * Shared constants and types for the wake and standby control group: the
 * register frame layout, field reset value, lane modes and sampling timing.
 * Assumes a single 100 MHz clock and a host that delivers decoded 16-bit
 * register frames from the serial register port.
 */
package wake_standby_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register frame
  localparam logic [2:0] REG_ADDR = 3'h2;
  localparam int ADDR_LSB = 13;
  localparam int ADDR_MSB = 15;
  localparam int FIELD_LSB = 0;
  localparam int FIELD_MSB = 9;
  localparam int FRAME_W = 16;

  // Edge selection codes for the local wake inputs
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Chip mode: upper bit set means Normal, clear means Standby or Sleep
  localparam int MODE_NORMAL_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int SHORT_INTERVAL_MS = 16;
  localparam int LONG_INTERVAL_MS = 64;
  localparam int SHORT_INTERVAL_CYC = SHORT_INTERVAL_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int LONG_INTERVAL_CYC = LONG_INTERVAL_MS * (NS_PER_MS / CLK_PERIOD_NS);
  // Bias settling time ahead of each synchronised sample
  localparam int BIAS_ON_CYC = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic lin_lane_one_standby_ctrl;
    logic lin_lane_two_standby_ctrl;
    logic [1:0] local_wake_one_edge_sel;
    logic [1:0] local_wake_two_edge_sel;
    logic can_lane_standby_ctrl;
    logic reset_level_sel;
    logic wake_one_sample_en;
    logic wake_two_sample_en;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '0;

  typedef enum logic [1:0] {
    LANE_OFF,
    LANE_ACTIVE,
    LANE_LOWPOWER
  } lane_mode_e;

  typedef struct packed {
    lane_mode_e mode;
    logic wake_det_en;
    logic wake_irq_allow;
    logic wake_flag_clr;
  } lane_ctrl_s;

  localparam lane_ctrl_s LANE_RESET = '{mode: LANE_OFF, default: 1'b0};

endpackage : wake_standby_pkg

// ===== rtl/lane_mode.sv
/*
 * Mode control for one transceiver lane: active, off or low-power with bus
 * wake detection, and gating of the lane's bus wake interrupt.
 * Assumes the standby bit and chip mode are registered in the clock domain.
 */
`timescale 1ns/1ps
module lane_mode (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic standby,
  input wire logic normal_mode,
  input wire logic bus_wake,
  output wake_standby_pkg::lane_ctrl_s lane_ctrl,
  output logic wake_irq
);

  wake_standby_pkg::lane_ctrl_s lane_d;
  wake_standby_pkg::lane_ctrl_s lane_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Low-power overrides the chip mode; otherwise Normal means active
  assign lane_d.mode = standby ? wake_standby_pkg::LANE_LOWPOWER :
                       (normal_mode ? wake_standby_pkg::LANE_ACTIVE :
                                      wake_standby_pkg::LANE_OFF);
  assign lane_d.wake_det_en = standby;
  assign lane_d.wake_irq_allow = standby;
  assign lane_d.wake_flag_clr = !standby && normal_mode;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_q <= wake_standby_pkg::LANE_RESET;
      irq_q <= 1'b0;
    end else begin
      lane_q <= lane_d;
      irq_q <= bus_wake && lane_q.wake_irq_allow;
    end
  end

  assign lane_ctrl = lane_q;
  assign wake_irq = irq_q;

endmodule : lane_mode

// ===== rtl/wake_sampler.sv
/*
 * Local wake input sampler with edge detection: samples continuously or on
 * bias-synchronised ticks, compares with the previous sample and raises a
 * one-cycle interrupt request on the selected edge.
 * Assumes the wake input is already synchronous to clk.
 */
`timescale 1ns/1ps
module wake_sampler (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sample_en,
  input wire logic tick,
  input wire logic wake_in,
  input wire logic [1:0] edge_sel,
  output logic wake_irq
);

  logic take;
  logic rise;
  logic fall;
  logic hit;
  logic sample_q;
  logic valid_q;
  logic irq_q;

  assign take = !sample_en || tick;
  assign rise = wake_in && !sample_q;
  assign fall = !wake_in && sample_q;
  // First sample only seeds the history, so reset cannot fake an edge
  assign hit = take && valid_q && ((rise && edge_sel[0]) || (fall && edge_sel[1]));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_q <= 1'b0;
      valid_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (take) begin
        sample_q <= wake_in;
        valid_q <= 1'b1;
      end
      irq_q <= hit;
    end
  end

  assign wake_irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_edge_raise;
    @(posedge clk) disable iff (!arst_n)
      take && valid_q && (rise || fall) && (edge_sel == wake_standby_pkg::EDGE_BOTH) |=> wake_irq;
  endproperty
  a_edge_raise: assert property (p_edge_raise) else $error("selected edge not raised");

  property p_no_change_no_irq;
    @(posedge clk) disable iff (!arst_n)
      (wake_in == sample_q) |=> !wake_irq;
  endproperty
  a_no_change_no_irq: assert property (p_no_change_no_irq) else $error("irq without change");

endmodule : wake_sampler

// ===== rtl/wake_standby_control.sv
/*
 * Lower field group of the interrupt and wake control register: lane standby
 * control, local wake edge selection and sampling, and reset level choice.
 * Assumes the serial register port delivers whole 16-bit frames with a
 * one-cycle write strobe; interrupt requests feed a status register elsewhere.
 */
`timescale 1ns/1ps

// Behaviour
// - Lane one off when clear in standby
// - Lane one set: low-power, wake detect, interrupts
// - Lane two clear, Normal: active, flag cleared
// - Lane two off when clear in standby
// - Lane two set: low-power, wake detect, interrupts
// - Bits 7:6 pick wake one edges
// - Bits 5:4 pick wake two edges
// - CAN clear, Normal: active, flag cleared
// - CAN off when clear in standby
// - CAN set: low-power, wake detect, interrupts
// - Bit 2 picks 90 or 70 percent
// - Lane one clear, Normal: active, flag cleared
// - Bias rate picks 16 or 64 ms
module wake_standby_control #(
  parameter int SHORT_INTERVAL_CYC = wake_standby_pkg::SHORT_INTERVAL_CYC,
  parameter int LONG_INTERVAL_CYC = wake_standby_pkg::LONG_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_wdata,
  output logic [15:0] ctrl_rdata,
  input wire logic [1:0] chip_mode_field,
  input wire logic bias_rate_sel,
  input wire logic local_wake_input_one,
  input wire logic local_wake_input_two,
  input wire logic lin1_bus_wake,
  input wire logic lin2_bus_wake,
  input wire logic can_bus_wake,
  output wake_standby_pkg::lane_ctrl_s lin1_ctrl,
  output wake_standby_pkg::lane_ctrl_s lin2_ctrl,
  output wake_standby_pkg::lane_ctrl_s can_ctrl,
  output logic lin1_wake_irq,
  output logic lin2_wake_irq,
  output logic can_wake_irq,
  output logic wake_one_irq,
  output logic wake_two_irq,
  output logic reset_level_sel,
  output logic wake_bias_output
);

  localparam int CNT_W = $clog2(LONG_INTERVAL_CYC + 1);

  if (SHORT_INTERVAL_CYC <= wake_standby_pkg::BIAS_ON_CYC ||
      LONG_INTERVAL_CYC <= wake_standby_pkg::BIAS_ON_CYC) begin : g_bad_interval
    $error("sampling interval must exceed the bias settling time");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode
  wake_standby_pkg::ctrl_s ctrl_q;
  wake_standby_pkg::ctrl_s ctrl_d;
  logic addr_hit;
  logic wr_take;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;

  assign addr_hit = ctrl_wdata[wake_standby_pkg::ADDR_MSB:wake_standby_pkg::ADDR_LSB] ==
                    wake_standby_pkg::REG_ADDR;
  assign wr_take = ctrl_wr && addr_hit;
  assign ctrl_d = wr_take ?
                  wake_standby_pkg::ctrl_s'(ctrl_wdata[wake_standby_pkg::FIELD_MSB:
                                                       wake_standby_pkg::FIELD_LSB]) :
                  ctrl_q;
  // Upper enables and lock bit live elsewhere and read as zero here
  assign rdata_d = {wake_standby_pkg::REG_ADDR, 3'h0, ctrl_q};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= wake_standby_pkg::CTRL_RESET;
      rdata_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign ctrl_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Supply reset level, registered so the analog side sees a clean level
  logic rth_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rth_q <= 1'b0;
    end else begin
      rth_q <= ctrl_q.reset_level_sel;
    end
  end

  assign reset_level_sel = rth_q;

  ////////////////////////////////////////////////////////////////////////////
  // Lane modes
  logic normal_mode;

  assign normal_mode = chip_mode_field[wake_standby_pkg::MODE_NORMAL_BIT];

  lane_mode u_lin1 (
    .clk(clk),
    .arst_n(arst_n),
    .standby(ctrl_q.lin_lane_one_standby_ctrl),
    .normal_mode(normal_mode),
    .bus_wake(lin1_bus_wake),
    .lane_ctrl(lin1_ctrl),
    .wake_irq(lin1_wake_irq)
  );

  lane_mode u_lin2 (
    .clk(clk),
    .arst_n(arst_n),
    .standby(ctrl_q.lin_lane_two_standby_ctrl),
    .normal_mode(normal_mode),
    .bus_wake(lin2_bus_wake),
    .lane_ctrl(lin2_ctrl),
    .wake_irq(lin2_wake_irq)
  );

  lane_mode u_can (
    .clk(clk),
    .arst_n(arst_n),
    .standby(ctrl_q.can_lane_standby_ctrl),
    .normal_mode(normal_mode),
    .bus_wake(can_bus_wake),
    .lane_ctrl(can_ctrl),
    .wake_irq(can_wake_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bias timer: one sample tick per interval, bias driven just before it.
  // Timer idles when neither input is bias-synchronised, saving power.
  logic bias_active;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic tick;
  logic bias_d;
  logic bias_q;

  assign bias_active = ctrl_q.wake_one_sample_en || ctrl_q.wake_two_sample_en;
  assign limit = bias_rate_sel ? CNT_W'(LONG_INTERVAL_CYC - 1) :
                                 CNT_W'(SHORT_INTERVAL_CYC - 1);
  assign tick = bias_active && (cnt_q >= limit);
  assign cnt_d = (!bias_active || tick) ? '0 : cnt_q + CNT_W'(1);
  assign bias_d = bias_active && (cnt_d > limit - CNT_W'(wake_standby_pkg::BIAS_ON_CYC));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      bias_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      bias_q <= bias_d;
    end
  end

  assign wake_bias_output = bias_q;

  ////////////////////////////////////////////////////////////////////////////
  // Local wake inputs
  wake_sampler u_wake_one (
    .clk(clk),
    .arst_n(arst_n),
    .sample_en(ctrl_q.wake_one_sample_en),
    .tick(tick),
    .wake_in(local_wake_input_one),
    .edge_sel(ctrl_q.local_wake_one_edge_sel),
    .wake_irq(wake_one_irq)
  );

  wake_sampler u_wake_two (
    .clk(clk),
    .arst_n(arst_n),
    .sample_en(ctrl_q.wake_two_sample_en),
    .tick(tick),
    .wake_in(local_wake_input_two),
    .edge_sel(ctrl_q.local_wake_two_edge_sel),
    .wake_irq(wake_two_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_lin1_clear_standby;
    !ctrl_q.lin_lane_one_standby_ctrl && !normal_mode;
  endsequence

  sequence s_lane_off(wake_standby_pkg::lane_ctrl_s lc);
    lc.mode == wake_standby_pkg::LANE_OFF && !lc.wake_det_en && !lc.wake_irq_allow;
  endsequence

  property p_lin1_off;
    @(posedge clk) disable iff (!arst_n)
      s_lin1_clear_standby |=> s_lane_off(lin1_ctrl);
  endproperty
  a_lin1_off: assert property (p_lin1_off) else $error("lane one not off");

  property p_lin1_lowpower;
    @(posedge clk) disable iff (!arst_n)
      ctrl_q.lin_lane_one_standby_ctrl |=>
        lin1_ctrl.mode == wake_standby_pkg::LANE_LOWPOWER && lin1_ctrl.wake_det_en;
  endproperty
  a_lin1_lowpower: assert property (p_lin1_lowpower) else $error("lane one not low-power");

  property p_lin1_active;
    @(posedge clk) disable iff (!arst_n)
      !ctrl_q.lin_lane_one_standby_ctrl && normal_mode |=>
        lin1_ctrl.mode == wake_standby_pkg::LANE_ACTIVE && lin1_ctrl.wake_flag_clr;
  endproperty
  a_lin1_active: assert property (p_lin1_active) else $error("lane one not active");

  property p_lin2_active;
    @(posedge clk) disable iff (!arst_n)
      !ctrl_q.lin_lane_two_standby_ctrl && normal_mode |=>
        lin2_ctrl.mode == wake_standby_pkg::LANE_ACTIVE && lin2_ctrl.wake_flag_clr;
  endproperty
  a_lin2_active: assert property (p_lin2_active) else $error("lane two not active");

  property p_lin2_off;
    @(posedge clk) disable iff (!arst_n)
      !ctrl_q.lin_lane_two_standby_ctrl && !normal_mode |=> s_lane_off(lin2_ctrl);
  endproperty
  a_lin2_off: assert property (p_lin2_off) else $error("lane two not off");

  property p_lin2_irq;
    @(posedge clk) disable iff (!arst_n)
      ctrl_q.lin_lane_two_standby_ctrl ##1 ctrl_q.lin_lane_two_standby_ctrl && lin2_bus_wake
        |=> lin2_wake_irq;
  endproperty
  a_lin2_irq: assert property (p_lin2_irq) else $error("lane two wake lost");

  property p_can_active;
    @(posedge clk) disable iff (!arst_n)
      !ctrl_q.can_lane_standby_ctrl && normal_mode |=>
        can_ctrl.mode == wake_standby_pkg::LANE_ACTIVE && can_ctrl.wake_flag_clr;
  endproperty
  a_can_active: assert property (p_can_active) else $error("CAN lane not active");

  property p_can_off;
    @(posedge clk) disable iff (!arst_n)
      (!ctrl_q.can_lane_standby_ctrl && !normal_mode)[*2] |->
        (!can_wake_irq) and s_lane_off(can_ctrl);
  endproperty
  a_can_off: assert property (p_can_off) else $error("CAN lane not off");

  property p_can_lowpower;
    @(posedge clk) disable iff (!arst_n)
      ctrl_q.can_lane_standby_ctrl |=>
        can_ctrl.mode == wake_standby_pkg::LANE_LOWPOWER && can_ctrl.wake_irq_allow;
  endproperty
  a_can_lowpower: assert property (p_can_lowpower) else $error("CAN lane not low-power");

  property p_wake_one_off;
    @(posedge clk) disable iff (!arst_n)
      ctrl_q.local_wake_one_edge_sel == wake_standby_pkg::EDGE_OFF |=> !wake_one_irq;
  endproperty
  a_wake_one_off: assert property (p_wake_one_off) else $error("wake one not disabled");

  property p_wake_two_rise_only;
    @(posedge clk) disable iff (!arst_n)
      ctrl_q.local_wake_two_edge_sel == wake_standby_pkg::EDGE_RISE |=>
        wake_two_irq |-> $past(local_wake_input_two);
  endproperty
  a_wake_two_rise_only: assert property (p_wake_two_rise_only) else $error("wake two edge");

  property p_level_follows_write;
    @(posedge clk) disable iff (!arst_n)
      wr_take |=> ##1 reset_level_sel == $past(ctrl_wdata[2], 2);
  endproperty
  a_level_follows_write: assert property (p_level_follows_write) else $error("level bit");

  property p_continuous_sampling;
    @(posedge clk) disable iff (!arst_n)
      !ctrl_q.wake_one_sample_en && !ctrl_q.wake_two_sample_en |=> !tick && !wake_bias_output;
  endproperty
  a_continuous_sampling: assert property (p_continuous_sampling) else $error("idle bias");

  property p_short_interval;
    @(posedge clk) disable iff (!arst_n)
      tick && !bias_rate_sel |=> cnt_q == '0 ##1 cnt_q == CNT_W'(1);
  endproperty
  a_short_interval: assert property (p_short_interval) else $error("interval restart");

  // Synchronised input may only raise its request from a sample taken on a tick
  property p_wake_two_sync;
    @(posedge clk) disable iff (!arst_n)
      ctrl_q.wake_two_sample_en && !tick |=> !wake_two_irq;
  endproperty
  a_wake_two_sync: assert property (p_wake_two_sync) else $error("wake two off tick");

  property p_write_applies;
    @(posedge clk) disable iff (!arst_n)
      wr_take |=> ctrl_q == $past(ctrl_wdata[9:0]) ##1 ctrl_rdata[9:0] == $past(ctrl_q);
  endproperty
  a_write_applies: assert property (p_write_applies) else $error("write not applied");

endmodule : wake_standby_control

// ===== verif/host_model.sv
/*
 * Behavioural host on the serial register port: sends whole decoded 16-bit
 * frames with a one-cycle write strobe, promptly or after an idle gap.
 * Assumes the bench clock and calls from the bench sequence.
 */
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic ctrl_wr,
  output logic [15:0] ctrl_wdata
);
  initial begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 16'hFFFF;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One frame, or two back to back; returns once the fields show at the outputs
  task automatic write_frames(input logic [15:0] first, input logic [15:0] second,
                              input bit two, input int gap);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = first;
    if (two) begin
      @(negedge clk);
      ctrl_wdata = second;
    end
    @(negedge clk);
    ctrl_wr = 1'b0;
    // Junk on released data, so a stale frame never looks valid
    ctrl_wdata = ~ctrl_wdata;
    @(negedge clk);
  endtask : write_frames
endmodule : host_model

// ===== verif/testbench.sv
/*
 * Self-checking bench for the wake and standby control group.
 * Assumes shortened sampling intervals and a host model on the register port.
 */
`timescale 1ns/1ps
module testbench;
  localparam int SHORT_CYC = 20;
  localparam int LONG_CYC = 40;
  localparam int MAX_CYC = 8000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ctrl_wr;
  logic [15:0] ctrl_wdata;
  wire [15:0] ctrl_rdata;
  logic [1:0] chip_mode_field = 2'h0;
  logic bias_rate_sel = 1'b0;
  logic [1:0] wake_in = 2'h0;
  logic [2:0] bus_wake = 3'h0;
  wake_standby_pkg::lane_ctrl_s lane_out [3];
  wire [2:0] lane_irq;
  wire [1:0] wake_irq;
  wire reset_level_sel;
  wire wake_bias_output;
  wire [5:0] probe;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int cnt [6];

  assign probe = {wake_bias_output, wake_irq, lane_irq};
  always #5 clk = ~clk;

  host_model i_host (.clk(clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata));

  wake_standby_control #(.SHORT_INTERVAL_CYC(SHORT_CYC), .LONG_INTERVAL_CYC(LONG_CYC)) i_dut (
    .clk(clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata), .chip_mode_field(chip_mode_field),
    .bias_rate_sel(bias_rate_sel), .local_wake_input_one(wake_in[0]),
    .local_wake_input_two(wake_in[1]), .lin1_bus_wake(bus_wake[0]),
    .lin2_bus_wake(bus_wake[1]), .can_bus_wake(bus_wake[2]), .lin1_ctrl(lane_out[0]),
    .lin2_ctrl(lane_out[1]), .can_ctrl(lane_out[2]), .lin1_wake_irq(lane_irq[0]),
    .lin2_wake_irq(lane_irq[1]), .can_wake_irq(lane_irq[2]), .wake_one_irq(wake_irq[0]),
    .wake_two_irq(wake_irq[1]), .reset_level_sel(reset_level_sel),
    .wake_bias_output(wake_bias_output)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] frame(input logic [2:0] s, input logic [1:0] e1,
                                        input logic [1:0] e2, input logic rl,
                                        input logic [1:0] wse);
    return {wake_standby_pkg::REG_ADDR, 3'h0, s[0], s[1], e1, e2, s[2], rl, wse};
  endfunction : frame

  function automatic wake_standby_pkg::lane_ctrl_s exp_lane(input logic stby, input logic nrm);
    wake_standby_pkg::lane_ctrl_s e;
    e = wake_standby_pkg::LANE_RESET;
    if (stby) begin
      e.mode = wake_standby_pkg::LANE_LOWPOWER;
      e.wake_det_en = 1'b1;
      e.wake_irq_allow = 1'b1;
    end else if (nrm) begin
      e.mode = wake_standby_pkg::LANE_ACTIVE;
      e.wake_flag_clr = 1'b1;
    end
    return e;
  endfunction : exp_lane

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk_lane(input wake_standby_pkg::lane_ctrl_s got,
                          input wake_standby_pkg::lane_ctrl_s exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: lane %h, expected %h", $time, got, exp);
    end
  endtask : chk_lane

  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      bad_count++;
      $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : chk_n

  task automatic wr(input logic [15:0] f, input int gap);
    i_host.write_frames(f, 16'h0000, 1'b0, gap);
  endtask : wr

  // Counts high cycles of every output event; bus wake stays a one-cycle pulse
  task automatic count_all(input int n, input bit clr);
    if (clr) cnt = '{default: 0};
    repeat (n) begin
      @(negedge clk);
      bus_wake = 3'h0;
      for (int k = 0; k < 6; k++) begin
        if (probe[k] === 1'b1) cnt[k]++;
      end
    end
  endtask : count_all

  // Aligns to the start of an interval, far from the next synchronised sample
  task automatic wait_bias_fall();
    int i;
    logic prev;
    prev = 1'b0;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      if (prev === 1'b1 && wake_bias_output === 1'b0) break;
      prev = wake_bias_output;
    end
    chk_n(i, i < 100 ? i : -1);
  endtask : wait_bias_fall

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      bad_count++;
      $display("wrong value at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    repeat (20) @(negedge clk);
    chk16(ctrl_rdata, 16'h0000);
    arst_n = 1'b1;
    @(negedge clk);
    chk16(ctrl_rdata, 16'h4000);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 8; s++) begin
        chip_mode_field = m[1:0];
        wr(frame(s[2:0], 2'h0, 2'h0, 1'b0, 2'h0), m);
        for (int i = 0; i < 3; i++) chk_lane(lane_out[i], exp_lane(s[i], m[1]));
      end
    end
    for (int p = 0; p < 2; p++) begin
      chip_mode_field = p ? 2'h2 : 2'h0;
      wr(frame(p ? 3'h2 : 3'h5, 2'h0, 2'h0, 1'b0, 2'h0), 0);
      bus_wake = 3'h7;
      count_all(3, 1);
      for (int i = 0; i < 3; i++) chk_n(cnt[i], p ? (i == 1) : (i != 1));
    end
    for (int rl = 0; rl < 2; rl++) begin
      wr(frame(3'h0, 2'h2, 2'h1, rl[0], 2'h0), 0);
      chk16({15'h0000, reset_level_sel}, rl[15:0]);
      chk16(ctrl_rdata, frame(3'h0, 2'h2, 2'h1, rl[0], 2'h0));
    end
    wr(16'h7FF8, 0);
    chk16(ctrl_rdata, frame(3'h0, 2'h2, 2'h1, 1'b1, 2'h0));
    wr(frame(3'h7, 2'h3, 2'h3, 1'b1, 2'h3) | 16'h1C00, 1);
    chk16(ctrl_rdata, frame(3'h7, 2'h3, 2'h3, 1'b1, 2'h3));
    i_host.write_frames(16'h43FF, 16'h4000, 1'b1, 0);
    chk16(ctrl_rdata, 16'h4000);
    for (int w = 0; w < 2; w++) begin
      for (int sel = 0; sel < 4; sel++) begin
        wr(frame(3'h0, w ? 2'h0 : sel[1:0], w ? sel[1:0] : 2'h0, 1'b0, 2'h0), 0);
        wake_in[w] = 1'b1;
        count_all(4, 1);
        chk_n(cnt[3 + w], sel & 1);
        wake_in[w] = 1'b0;
        count_all(4, 1);
        chk_n(cnt[3 + w], sel >> 1);
      end
    end
    count_all(LONG_CYC, 1);
    chk_n(cnt[5], 0);
    for (int w = 0; w < 2; w++) begin
      wr(frame(3'h0, 2'h3, 2'h3, 1'b0, w ? 2'h1 : 2'h2), 0);
      count_all(2 * SHORT_CYC, 1);
      chk_n(cnt[5], 8);
      wait_bias_fall();
      wake_in = 2'h3;
      count_all(2, 1);
      wake_in = 2'h0;
      count_all(6, 0);
      chk_n(cnt[3 + w], 0);
      chk_n(cnt[4 - w], 2);
      wake_in = 2'h3;
      count_all(SHORT_CYC + 6, 1);
      chk_n(cnt[3 + w], 1);
      wake_in = 2'h0;
      count_all(SHORT_CYC + 6, 1);
    end
    bias_rate_sel = 1'b1;
    count_all(LONG_CYC, 1);
    count_all(2 * LONG_CYC, 1);
    chk_n(cnt[5], 8);
    arst_n = 1'b0;
    @(negedge clk);
    chk16(ctrl_rdata, 16'h0000);
    arst_n = 1'b1;
    @(negedge clk);
    chk16(ctrl_rdata, 16'h4000);
    print_verdict();
  end
endmodule : testbench
